/* File: hw/gpcb_pkg.sv */
// Constants for the per-pin configuration bank
package gpcb_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int PIN_COUNT = 8;                      // Pins in the port
  localparam int SEL_W     = 3;                      // Width of the pin index

  // ----------------------------------------
  // Configuration field positions
  // ----------------------------------------
  localparam int CFG_OUT_EN   = 0;                   // Drive enable
  localparam int CFG_PUSH     = 1;                   // 1 push-pull, 0 open-drain
  localparam int CFG_PULLUP   = 2;                   // Weak pull-up enable
  localparam int CFG_LOCK     = 3;                   // Sticky lock
  localparam int CFG_EV_LEVEL = 4;                   // 1 level, 0 edge
  localparam int CFG_EV_POL   = 5;                   // 1 rising/high
  localparam int CFG_DEB_EN   = 6;                   // Debounce enable

  // ----------------------------------------
  // Reset values and masks
  // ----------------------------------------
  localparam logic [7:0] CFG_RESET    = 8'h44;       // Debounce and pull-up on
  localparam logic [7:0] CFG_RW_MASK  = 8'h7f;       // Bit 7 reserved
  localparam logic [7:0] CFG_EV_MASK  = 8'h70;       // Event fields
  localparam logic [7:0] CFG_LOCKED   = 8'h0f;       // Fields frozen by lock
  localparam logic [7:0] DOUT_RESET   = 8'hff;       // Data out latch reset

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ       = 100_000_000;         // Clock rate
  localparam int DEB_MS       = 15;                  // Quiet time before pass
  localparam int DEB_CYCLES   = CLK_HZ / 1000 * DEB_MS;
  localparam int DEB_W        = 21;                  // Counter width

endpackage

/* File: hw/gpcb_bank.sv */
// Per-pin configuration bank with lock, pin drive and debounced event inputs
//
// Contract
// - Eight pin registers behind one select index
// - Basic variant: bits 4-6 read zero
// - Bit 6 enables debounce, resets one
// - Bit 5 event polarity, resets zero
// - Bit 4 edge or level, resets edge
// - Lock bit set-only, cleared by reset
// - Lock freezes direction, type, pull-up, value
// - Lock leaves pin multiplexing untouched
// - Bit 2 weak pull-up, resets one
// - Bit 1 open-drain or push-pull
// - Bit 0 drive enable, input unaffected
// - Debounce needs 15 ms quiet time
// - Lock blocks data-out and bits 0-3
`timescale 1ns/1ps

module gpcb_bank #(
  parameter bit EVENTS        = 1'b1,                // Enhanced port with events
  parameter int DEB_CYCLES_P  = gpcb_pkg::DEB_CYCLES // Debounce quiet time
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic                          clk_en,
  // Configuration space access
  input  wire logic [gpcb_pkg::SEL_W-1:0]    pin_select_index,
  input  wire logic                          cfg_wr,
  input  wire logic [7:0]                    cfg_wdata,
  output logic      [7:0]                    pin_configuration,
  // Data out latch access
  input  wire logic                          dout_wr,
  input  wire logic [7:0]                    dout_wdata,
  output logic      [7:0]                    data_out_latch,
  // Pin side
  input  wire logic [gpcb_pkg::PIN_COUNT-1:0] pin_in,
  output logic      [gpcb_pkg::PIN_COUNT-1:0] pin_out,
  output logic      [gpcb_pkg::PIN_COUNT-1:0] pin_oe,
  output logic      [gpcb_pkg::PIN_COUNT-1:0] pin_pullup,
  // Event detector side
  output logic      [gpcb_pkg::PIN_COUNT-1:0] ev_level,
  output logic      [gpcb_pkg::PIN_COUNT-1:0] ev_pol,
  output logic      [gpcb_pkg::PIN_COUNT-1:0] ev_input
);
  import gpcb_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [PIN_COUNT-1:0][7:0]       cfg;    // Configuration per pin
    logic [7:0]                      dout;   // Data out latch
    logic [PIN_COUNT-1:0][2:0]       sync;   // Pin synchronisers
    logic [PIN_COUNT-1:0]            stable; // Debounced level
    logic [PIN_COUNT-1:0][DEB_W-1:0] cnt;    // Quiet-time counters
    logic [7:0]                      rd;     // Read data register
    logic [PIN_COUNT-1:0]            p_out;  // Pin output value
    logic [PIN_COUNT-1:0]            p_oe;   // Pin drive enable
    logic [PIN_COUNT-1:0]            p_pu;   // Pull-up enable
    logic [PIN_COUNT-1:0]            e_lvl;  // Event type out
    logic [PIN_COUNT-1:0]            e_pol;  // Event polarity out
    logic [PIN_COUNT-1:0]            e_in;   // Event detector input
  } gpcb_state_t;

  gpcb_state_t st;                           // Registered state
  gpcb_state_t next_st;                      // Next state

  // Terminal count of the quiet-time counter and the visible field mask
  localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEB_CYCLES_P - 1); // Terminal count
  localparam logic [7:0] READ_MASK = EVENTS ? CFG_RW_MASK : (CFG_RW_MASK & ~CFG_EV_MASK);

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // The lock is judged on the stored value, not on the write data,
  // so a write that sets the lock still lands its other bits in the
  // same cycle; only later writes to bits 0-3 of that pin are refused.
  always_comb begin
    logic [7:0] wmask;                       // Writable bits of the selected pin
    logic [7:0] cur;                         // Selected pin value
    logic       drv;                         // Pin drive condition
    logic       ein;                         // Event source level
    next_st = st;
    wmask   = 8'h00;
    cur     = 8'h00;
    drv     = 1'b0;
    ein     = 1'b0;
    // Configuration write to the selected pin only
    cur = st.cfg[pin_select_index];
    if (cfg_wr) begin
      wmask = READ_MASK;
      if (cur[CFG_LOCK]) begin
        wmask = wmask & ~CFG_LOCKED;
      end
      // Lock touches no multiplexing select, only fields 0-3
      // Lock is only ever ORed in, never cleared by writes
      next_st.cfg[pin_select_index] = (cur & ~wmask) | (cfg_wdata & wmask)
                                      | (cur & 8'h08);
    end
    // Per-pin data out, drive and debounce
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (dout_wr && !st.cfg[i][CFG_LOCK]) begin
        next_st.dout[i] = dout_wdata[i];
      end
      // A pin that bounces faster than the quiet time never reaches the
      // detector; the counter restarts on every disagreement.
      // Three-stage synchroniser; a change counts when stages 2 and 3 agree
      next_st.sync[i] = {st.sync[i][1:0], pin_in[i]};
      if (st.sync[i][2] != st.sync[i][1] || st.sync[i][2] == st.stable[i]) begin
        next_st.cnt[i] = '0;
      end else if (st.cnt[i] == DEB_LAST) begin
        next_st.stable[i] = st.sync[i][2];
        next_st.cnt[i]    = '0;
      end else begin
        next_st.cnt[i] = st.cnt[i] + 1'b1;
      end
      // An open-drain pin releases high by dropping its enable, leaving
      // the pull-up, when on, to lift the line.
      // Open-drain drives only low; push-pull drives both levels
      drv = st.cfg[i][CFG_OUT_EN] && (st.cfg[i][CFG_PUSH] || !st.dout[i]);
      next_st.p_oe[i]  = drv;
      next_st.p_out[i] = st.dout[i];
      next_st.p_pu[i]  = st.cfg[i][CFG_PULLUP];
      // In the basic variant the event outputs stay low whatever is stored
      // Debounce bypass picks the synchronised level directly
      ein = (EVENTS && st.cfg[i][CFG_DEB_EN]) ? st.stable[i] : st.sync[i][2];
      next_st.e_in[i]  = EVENTS ? ein : 1'b0;
      next_st.e_lvl[i] = EVENTS && st.cfg[i][CFG_EV_LEVEL];
      next_st.e_pol[i] = EVENTS && st.cfg[i][CFG_EV_POL];
    end
    // Read-back of selected pin; reserved and absent fields zero
    next_st.rd = next_st.cfg[pin_select_index] & READ_MASK;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Reset ignores the clock enable so a frozen block still comes up clean.
  // Synchronisers start low to match a quiet pin and the debounced level.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // Every pin register comes up with debounce and pull-up on
      for (int i = 0; i < PIN_COUNT; i++) begin
        st.cfg[i]    <= CFG_RESET;
        st.sync[i]   <= 3'h0;
        st.cnt[i]    <= '0;
      end
      st.dout   <= DOUT_RESET;
      st.stable <= '0;
      st.rd     <= CFG_RESET & READ_MASK;
      st.p_out  <= '1;
      st.p_oe   <= '0;
      st.p_pu   <= '1;
      st.e_lvl  <= '0;
      st.e_pol  <= '0;
      st.e_in   <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output is a bare register; no logic sits between state and pin
  assign pin_configuration = st.rd;
  assign data_out_latch    = st.dout;
  assign pin_out           = st.p_out;
  assign pin_oe            = st.p_oe;
  assign pin_pullup        = st.p_pu;
  assign ev_level          = st.e_lvl;
  assign ev_pol            = st.e_pol;
  assign ev_input          = st.e_in;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  lock_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(st.cfg[0][CFG_LOCK]) |=> st.cfg[0][CFG_LOCK] [*8])
    else $error("lock bit cleared without reset");

  lock_freeze_a: assert property (@(posedge clk) disable iff (sys_rst)
    st.cfg[1][CFG_LOCK] |=> st.cfg[1][3:0] == $past(st.cfg[1][3:0]))
    else $error("locked low bits changed");

  dout_frozen_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st.cfg[2][CFG_LOCK] && dout_wr) |=> st.dout[2] == $past(st.dout[2]))
    else $error("locked data out changed");

  reserved_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    pin_configuration[7] == 1'b0)
    else $error("reserved bit read nonzero");

  write_lands_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && cfg_wr && !st.cfg[pin_select_index][CFG_LOCK])
      |=> pin_configuration == ($past(cfg_wdata) & READ_MASK))
    else $error("write not visible on read");

  od_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && !st.cfg[3][CFG_PUSH] && st.dout[3]) |=> !pin_oe[3])
    else $error("open drain drove high");

  oe_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && !st.cfg[4][CFG_OUT_EN]) |=> !pin_oe[4])
    else $error("pin driven while disabled");

  pullup_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en |=> pin_pullup[5] == $past(st.cfg[5][CFG_PULLUP]))
    else $error("pull-up not following bit");

  deb_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st.stable[6] != $past(st.stable[6])) |-> $past(st.cnt[6]) == DEB_LAST)
    else $error("debounced level changed early");

  bypass_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && EVENTS && !st.cfg[7][CFG_DEB_EN]) |=> ev_input[7] == $past(st.sync[7][2]))
    else $error("bypass not taken");

  // Reset brings the visible outputs to their documented levels
  reset_values_a: assert property (@(posedge clk)
    sys_rst |=> (pin_configuration == (CFG_RESET & READ_MASK)) && (data_out_latch == DOUT_RESET)
      && (pin_oe == '0) && (pin_pullup == '1))
    else $error("reset values wrong");

  // Basic variant shows no event fields and feeds no detector
  basic_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    !EVENTS |-> (pin_configuration[6:4] == 3'h0) && (ev_input == '0) && (ev_level == '0))
    else $error("basic variant shows events");

  // Read-back follows the index when nothing is written
  readback_idx_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && !cfg_wr) |=> pin_configuration == ($past(st.cfg[pin_select_index]) & READ_MASK))
    else $error("read-back not from index");

  // ----------------------------------------
  // Per-pin checks
  // ----------------------------------------
  // Each pin is watched, so stimulus on any pin exercises these checks
  for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin_chk
    // Lock survives every write
    lock_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      st.cfg[g][CFG_LOCK] |=> st.cfg[g][CFG_LOCK])
      else $error("pin lock bit dropped");

    // Locked low fields never move
    lock_fields_a: assert property (@(posedge clk) disable iff (sys_rst)
      st.cfg[g][CFG_LOCK] |=> st.cfg[g][3:0] == $past(st.cfg[g][3:0]))
      else $error("locked pin fields changed");

    // Locked pin keeps its driven value
    lock_dout_a: assert property (@(posedge clk) disable iff (sys_rst)
      st.cfg[g][CFG_LOCK] |=> st.dout[g] == $past(st.dout[g]))
      else $error("locked pin value changed");

    // Unlocked data out takes the written bit
    dout_lands_a: assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && dout_wr && !st.cfg[g][CFG_LOCK]) |=> st.dout[g] == $past(dout_wdata[g]))
      else $error("data out write lost");

    // A write to another pin leaves this one alone
    other_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && cfg_wr && pin_select_index != SEL_W'(g)) |=> st.cfg[g] == $past(st.cfg[g]))
      else $error("write hit wrong pin");

    // Reserved bit is never stored
    rsvd_store_a: assert property (@(posedge clk) disable iff (sys_rst)
      st.cfg[g][7] == 1'b0)
      else $error("reserved bit stored");

    // Debounced level moves only at the terminal count
    deb_change_a: assert property (@(posedge clk) disable iff (sys_rst)
      (st.stable[g] != $past(st.stable[g])) |-> $past(st.cnt[g]) == DEB_LAST)
      else $error("debounced pin changed early");

    // Quiet-time counter stays in range
    cnt_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
      st.cnt[g] <= DEB_LAST)
      else $error("debounce counter overran");

    // Bypass feeds the synchronised level
    bypass_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && EVENTS && !st.cfg[g][CFG_DEB_EN]) |=> ev_input[g] == $past(st.sync[g][2]))
      else $error("pin bypass not taken");

    // Enabled debounce feeds the filtered level
    deb_path_a: assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && EVENTS && st.cfg[g][CFG_DEB_EN]) |=> ev_input[g] == $past(st.stable[g]))
      else $error("debounce path not taken");

    // Event polarity follows its field
    ev_pol_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en |=> ev_pol[g] == (EVENTS && $past(st.cfg[g][CFG_EV_POL])))
      else $error("event polarity wrong");

    // Event type follows its field
    ev_type_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en |=> ev_level[g] == (EVENTS && $past(st.cfg[g][CFG_EV_LEVEL])))
      else $error("event type wrong");

    // Push-pull with drive enabled always drives
    push_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && st.cfg[g][CFG_OUT_EN] && st.cfg[g][CFG_PUSH]) |=> pin_oe[g])
      else $error("push-pull pin not driven");

    // Pin value follows the data out latch
    out_value_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en |=> pin_out[g] == $past(st.dout[g]))
      else $error("pin value not from latch");
  end

endmodule

/* File: test/test_gpio_pin_config_bank.sv */
// Self-checking bench for the per-pin configuration bank
`timescale 1ns/1ps
module test_gpio_pin_config_bank;
  import gpcb_pkg::*;
  // ------------------------------
  // Stimulus and observed signals
  // ------------------------------
  logic       clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;      // Clock, reset, advance
  logic [2:0] pin_select_index = 3'h0;                         // Pin index
  logic       cfg_wr = 1'b0, dout_wr = 1'b0;                   // Write strobes
  logic [7:0] cfg_wdata = 8'h00, dout_wdata = 8'h00;           // Write data
  logic [7:0] pin_in = 8'h00;                                  // Pin levels
  logic [7:0] pin_configuration, data_out_latch, basic_cfg;    // Read values
  logic [7:0] pin_out, pin_oe, pin_pullup, ev_level, ev_pol, ev_input;
  logic [7:0] cfg_m [8];                                       // Expected per-pin config
  logic [7:0] dout_m;                                          // Expected data out
  int         failures = 0, total_checks = 0;                  // Counters
  typedef struct packed {logic [2:0] s; logic [7:0] d; logic [7:0] e;} gpcb_row_t;
  gpcb_row_t  rows [6] = '{'{3'h1, 8'h00, 8'h00}, '{3'h2, 8'h03, 8'h03}, '{3'h3, 8'hb6, 8'h36},
                           '{3'h4, 8'h21, 8'h21}, '{3'h6, 8'h54, 8'h54}, '{3'h7, 8'h92, 8'h12}};
  // Enhanced port under test, short debounce
  gpcb_bank #(.EVENTS(1'b1), .DEB_CYCLES_P(8)) uut (.clk, .sys_rst, .clk_en, .pin_select_index,
    .cfg_wr, .cfg_wdata, .pin_configuration, .dout_wr, .dout_wdata, .data_out_latch, .pin_in,
    .pin_out, .pin_oe, .pin_pullup, .ev_level, .ev_pol, .ev_input);
  // Basic port fed the same writes
  gpcb_bank #(.EVENTS(1'b0), .DEB_CYCLES_P(8)) uut_basic (.clk, .sys_rst, .clk_en,
    .pin_select_index, .cfg_wr, .cfg_wdata, .pin_configuration(basic_cfg), .dout_wr,
    .dout_wdata, .data_out_latch(), .pin_in, .pin_out(), .pin_oe(), .pin_pullup(),
    .ev_level(), .ev_pol(), .ev_input());
  always #5 clk = ~clk;
  // ------------------------------
  // Shared tasks
  // ------------------------------
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task check(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Write one pin register; locked pins keep bits 0-3
  task cfg_write(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk);
    pin_select_index <= s;
    cfg_wr <= 1'b1;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg_m[s] = cfg_m[s][3] ? {1'b0, d[6:4], cfg_m[s][3:0]} : {1'b0, d[6:0]};
  endtask
  task dout_write(input logic [7:0] d);
    @(posedge clk);
    dout_wr <= 1'b1;
    dout_wdata <= d;
    @(posedge clk);
    dout_wr <= 1'b0;
    for (int i = 0; i < 8; i++) if (!cfg_m[i][3]) dout_m[i] = d[i];
  endtask
  task cfg_check(input logic [2:0] s, input logic [7:0] e);
    @(posedge clk);
    pin_select_index <= s;
    tick(2);
    #1;
    check("pin_configuration", e, pin_configuration);
    check("basic_cfg", e & 8'h0f, basic_cfg);
  endtask
  // Pin side compared with the expected register image
  task out_check;
    logic [7:0] oe, pu, lv, pl;
    tick(3);
    #1;
    for (int i = 0; i < 8; i++) begin
      oe[i] = cfg_m[i][0] & (cfg_m[i][1] | ~dout_m[i]);
      {pl[i], lv[i], pu[i]} = {cfg_m[i][5], cfg_m[i][4], cfg_m[i][2]};
    end
    check("pin_oe", oe, pin_oe);
    check("pin_out", dout_m, pin_out);
    check("pin_pullup", pu, pin_pullup);
    check("ev_level", lv, ev_level);
    check("ev_pol", pl, ev_pol);
    check("data_out_latch", dout_m, data_out_latch);
  endtask
  task do_reset(input int n);
    @(posedge clk);
    sys_rst <= 1'b1;
    tick(n);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) cfg_m[i] = 8'h44;
    dout_m = 8'hff;
    cfg_check(3'h5, 8'h44);
    out_check();
    $display("reset test done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    do_reset(16);
    foreach (rows[i]) begin
      cfg_write(rows[i].s, rows[i].d);
      cfg_check(rows[i].s, rows[i].e);
    end
    out_check();
    $display("table test done");
    cfg_write(3'h5, 8'h09);
    dout_write(8'h00);
    cfg_write(3'h5, 8'h70);
    cfg_check(3'h5, 8'h79);
    out_check();
    $display("lock test done");
    @(posedge clk) clk_en <= 1'b0;
    cfg_write(3'h6, 8'h00);
    cfg_m[6] = 8'h54;
    clk_en <= 1'b1;
    cfg_check(3'h6, 8'h54);
    $display("freeze test done");
    @(posedge clk) pin_in <= 8'h03;
    tick(6);
    #1 check("ev_input", 8'h02, ev_input & 8'h03);
    tick(10);
    #1 check("ev_input", 8'h03, ev_input & 8'h03);
    @(posedge clk) pin_in <= 8'h02;
    tick(4);
    pin_in <= 8'h03;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk) #1 check("ev_input0", 8'h01, ev_input & 8'h01);
    end
    $display("debounce test done");
    do_reset(2);
    wrap_up();
  end
  // Watchdog against a hang
  initial begin
    #200000;
    failures++;
    wrap_up();
  end
endmodule
